// >>> logic/wibs_consts.svh
// offsets, fields and timing counts of the wake sense block
`ifndef WIBS_CONSTS_SVH
`define WIBS_CONSTS_SVH
`define WIBS_OFF_BIAS_CTRL 12'h000
`define WIBS_OFF_WAKE_EN 12'h004
`define WIBS_OFF_MODE 12'h008
`define WIBS_OFF_EVT_STAT 12'h00c
`define WIBS_OFF_LVL_STAT 12'h010
`define WIBS_OFF_IRQ_EN 12'h014
`define WIBS_OFF_IRQ_CLR 12'h018
`define WIBS_OFF_SLEEP_REQ 12'h01c
`define WIBS_OFF_FUNC_STAT 12'h020
`define WIBS_BIAS_NONE 2'h0
`define WIBS_BIAS_DOWN 2'h1
`define WIBS_BIAS_UP 2'h2
`define WIBS_BIAS_AUTO 2'h3
`define WIBS_MODE_CYCLIC_BIT 0
`define WIBS_MODE_MEAS_BIT 1
`define WIBS_MODE_LOWPWR_BIT 2
`define WIBS_MODE_FOTEST_BIT 3
`define WIBS_MODE_GPIO_BIT 4
`define WIBS_MODE_OTHERWK_BIT 5
`define WIBS_EVT_WAKE_BIT 0
`define WIBS_EVT_FAULT_BIT 1
`define WIBS_FILTER_NS 16000
`define WIBS_CLK_NS 40
`define WIBS_FILTER_CYC (`WIBS_FILTER_NS / `WIBS_CLK_NS)
`endif

// >>> logic/wibs_core.sv
// wake input bias, sense, filter and measurement control with apb registers
`timescale 1ns/1ps
`include "wibs_consts.svh"
// Functional notes
// - bias code 00 gives no source and is reset, 01 pull-down, 10 pull-up.
// - bias code 11 pulls up while level is high and down while low.
// - in low power, cyclic sensing samples the pin only during high-side on time.
// - a cyclic sample differing from the last one raises a wake event.
// - measure select routes the sense pin voltage to the fail/gpio pin.
// - measure select disables fail out, its test bit, gpio and wake.
// - measure select turns off both bias sources and blocks wake.
// - measure select ignores stored bias, and wake enable for wake events, but keeps writes.
// - measure select stops wake events setting event status and clears level status.
// - measure with only this wake source turns sleep into restart + fault.
// - static sensing filters level changes for 16 us (13 to 20 us).
// - each new crossing restarts the filter.
// - both edges signal: interrupt when awake, wake-up when asleep.
// - cyclic sensing reports the last sampled level.
module wibs_core (
  input wire logic i_clk, // 25 MHz clock
  input wire logic i_reset, // sync reset, active high
  input wire logic [11:0] i_paddr, // apb address
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb write
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  input wire logic i_hv_sense_pin, // comparator output of sense pin
  input wire logic i_high_side_on, // timer high-side on phase
  output logic o_pull_up_en, // pull-up source enable
  output logic o_pull_down_en, // pull-down source enable
  output logic o_meas_route_en, // route pin voltage to fail/gpio pin
  output logic o_fail_out_en, // fail-output function allowed
  output logic o_fail_out_test_on, // effective fail out test
  output logic o_gpio_en, // gpio function allowed
  output logic o_wake_internal, // gated internal wake level
  output logic o_wake_event, // one-cycle wake pulse
  output logic o_wakeup_req, // wake-up request pulse when asleep
  output logic o_restart_req, // restart request pulse
  output logic o_irq // level interrupt
);
  typedef struct packed {
    logic [1:0] bias_select_field;
    logic wake_enable_reg;
    logic [5:0] mode;
    logic [1:0] wake_event_status;
    logic pin_level_status;
    logic [1:0] irq_en;
    logic sampled;
    logic hs_prev;
    logic sleeping;
    logic wake_pulse;
    logic wakeup_pulse;
    logic restart_pulse;
    logic [31:0] prdata;
    logic pslverr;
  } wibs_core_s;
  wibs_core_s st;
  wibs_core_s next_st;
  wibs_pkg::wibs_apb_req_s req;
  logic [1:0] pin_sync;
  logic hs_sync1;
  logic hs_sync2;
  logic flt_level;
  logic flt_change;
  logic meas;
  logic cyclic;
  logic lowpwr;
  logic wr_acc;
  logic rd_acc;
  logic sample_now;
  logic live_level;
  logic bias_level;
  logic [1:0] eff_bias;
  logic evt;

  assign req = '{paddr: i_paddr, psel: i_psel, penable: i_penable,
                 pwrite: i_pwrite, pwdata: i_pwdata};
  // pin and timer inputs cross into the clock domain
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_sync <= 2'h0;
      hs_sync1 <= 1'b0;
      hs_sync2 <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], i_hv_sense_pin};
      hs_sync1 <= i_high_side_on;
      hs_sync2 <= hs_sync1;
    end
  end

  wibs_filter #(
    .CYCLES(`WIBS_FILTER_CYC)
  ) u_filter (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_level(pin_sync[1]),
    .o_level(flt_level),
    .o_change(flt_change)
  );

  assign meas = st.mode[`WIBS_MODE_MEAS_BIT];
  assign cyclic = st.mode[`WIBS_MODE_CYCLIC_BIT];
  assign lowpwr = st.mode[`WIBS_MODE_LOWPWR_BIT];
  assign wr_acc = req.psel && req.penable && req.pwrite;
  assign rd_acc = req.psel && !req.penable && !req.pwrite;
  // sample only in the high-side on phase in low power
  assign sample_now = cyclic && lowpwr && hs_sync2 && !st.hs_prev;
  // cyclic sensing shows the last sample
  assign live_level = cyclic ? st.sampled : flt_level;
  assign bias_level = cyclic ? st.sampled : pin_sync[1];
  // stored bias is ignored while measuring
  assign eff_bias = meas ? `WIBS_BIAS_NONE : st.bias_select_field;
  assign evt = cyclic ? (sample_now && (pin_sync[1] != st.sampled))
                      : flt_change;

  always_comb begin
    next_st = st;
    next_st.wake_pulse = 1'b0;
    next_st.wakeup_pulse = 1'b0;
    next_st.restart_pulse = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.hs_prev = hs_sync2;
    if (sample_now && !meas) begin
      next_st.sampled = pin_sync[1];
    end
    if (rd_acc) begin
      unique case (req.paddr)
        `WIBS_OFF_BIAS_CTRL: next_st.prdata = {30'h0, st.bias_select_field};
        `WIBS_OFF_WAKE_EN: next_st.prdata = {31'h0, st.wake_enable_reg};
        `WIBS_OFF_MODE: next_st.prdata = {26'h0, st.mode};
        `WIBS_OFF_EVT_STAT: next_st.prdata = {30'h0, st.wake_event_status};
        `WIBS_OFF_LVL_STAT: next_st.prdata = {31'h0, st.pin_level_status};
        `WIBS_OFF_IRQ_EN: next_st.prdata = {30'h0, st.irq_en};
        `WIBS_OFF_FUNC_STAT:
          next_st.prdata = {29'h0, st.sleeping, o_pull_up_en, o_pull_down_en};
        `WIBS_OFF_IRQ_CLR, `WIBS_OFF_SLEEP_REQ: next_st.prdata = 32'h0;
        default: begin
          next_st.prdata = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end else if (req.psel && !req.penable && req.pwrite) begin
      next_st.pslverr = !(req.paddr inside {`WIBS_OFF_BIAS_CTRL,
        `WIBS_OFF_WAKE_EN, `WIBS_OFF_MODE, `WIBS_OFF_IRQ_EN,
        `WIBS_OFF_IRQ_CLR, `WIBS_OFF_SLEEP_REQ});
    end else if (req.psel && req.penable) begin
      next_st.pslverr = st.pslverr;
    end
    if (wr_acc) begin
      unique case (req.paddr)
        // writes are stored even while measuring
        `WIBS_OFF_BIAS_CTRL: next_st.bias_select_field = req.pwdata[1:0];
        `WIBS_OFF_WAKE_EN: next_st.wake_enable_reg = req.pwdata[0];
        `WIBS_OFF_MODE: next_st.mode = req.pwdata[5:0];
        `WIBS_OFF_IRQ_EN: next_st.irq_en = req.pwdata[1:0];
        `WIBS_OFF_IRQ_CLR:
          next_st.wake_event_status = st.wake_event_status & ~req.pwdata[1:0];
        `WIBS_OFF_SLEEP_REQ: begin
          if (req.pwdata[0]) begin
            // sleep refused when only this source is valid
            if (meas && st.wake_enable_reg &&
                !st.mode[`WIBS_MODE_OTHERWK_BIT]) begin
              next_st.wake_event_status[`WIBS_EVT_FAULT_BIT] = 1'b1;
              next_st.restart_pulse = 1'b1;
            end else begin
              next_st.sleeping = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // level cleared from the cycle a measure write completes
    if (next_st.mode[`WIBS_MODE_MEAS_BIT]) begin
      next_st.pin_level_status = 1'b0;
    end else begin
      next_st.pin_level_status = live_level;
    end
    // wake enable only counts outside measurement
    if (evt && !meas && st.wake_enable_reg) begin
      next_st.wake_event_status[`WIBS_EVT_WAKE_BIT] = 1'b1;
      next_st.wake_pulse = 1'b1;
      // asleep: wake the device, awake: interrupt
      if (st.sleeping) begin
        next_st.wakeup_pulse = 1'b1;
        next_st.sleeping = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    o_pull_up_en = 1'b0;
    o_pull_down_en = 1'b0;
    unique case (eff_bias)
      `WIBS_BIAS_DOWN: o_pull_down_en = 1'b1;
      `WIBS_BIAS_UP: o_pull_up_en = 1'b1;
      `WIBS_BIAS_AUTO: begin
        o_pull_up_en = bias_level;
        o_pull_down_en = !bias_level;
      end
      default: begin
      end
    endcase
  end

  assign o_meas_route_en = meas;
  assign o_fail_out_en = !meas;
  assign o_fail_out_test_on = st.mode[`WIBS_MODE_FOTEST_BIT] && !meas;
  assign o_gpio_en = st.mode[`WIBS_MODE_GPIO_BIT] && !meas;
  assign o_wake_internal = meas ? 1'b0 : live_level;
  assign o_wake_event = st.wake_pulse;
  assign o_wakeup_req = st.wakeup_pulse;
  assign o_restart_req = st.restart_pulse;
  assign o_irq = |(st.wake_event_status & st.irq_en) && !st.sleeping;
  assign o_prdata = st.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = st.pslverr && req.psel && req.penable;

  meas_bias_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    meas |-> !o_pull_up_en && !o_pull_down_en)
    else $error("bias active in measurement");
  auto_bias_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (eff_bias == `WIBS_BIAS_AUTO) |-> o_pull_up_en == bias_level
      && o_pull_down_en == !bias_level)
    else $error("auto bias wrong");
  fixed_bias_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (eff_bias == `WIBS_BIAS_UP) |-> o_pull_up_en && !o_pull_down_en)
    else $error("pull-up code wrong");
  // level cleared in the same cycle that measurement starts
  level_cleared_a: assert property (@(posedge i_clk) disable iff (i_reset)
    meas |-> st.pin_level_status == 1'b0)
    else $error("level status not cleared");
  evt_frozen_a: assert property (@(posedge i_clk) disable iff (i_reset)
    meas && $past(meas) && !$past(wr_acc)
      |-> $stable(st.wake_event_status))
    else $error("event status changed in measurement");
  sleep_refused_a: assert property (@(posedge i_clk) disable iff (i_reset)
    st.restart_pulse |-> st.wake_event_status[`WIBS_EVT_FAULT_BIT]
      && !st.sleeping)
    else $error("restart without fault flag");
  meas_funcs_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    meas |-> !o_fail_out_en && !o_gpio_en && !o_fail_out_test_on
      && !o_wake_internal)
    else $error("function active in measurement");
  // sample holds outside the on phase
  sample_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !$past(sample_now) |-> $stable(st.sampled))
    else $error("sample changed off phase");
  wakeup_sleep_a: assert property (@(posedge i_clk) disable iff (i_reset)
    st.wakeup_pulse |-> $past(st.sleeping) && st.wake_pulse)
    else $error("wake-up without sleep");
endmodule

// >>> logic/wibs_filter.sv
// restartable level filter for the static sense path
`timescale 1ns/1ps
`include "wibs_consts.svh"
module wibs_filter #(
  parameter int CYCLES = `WIBS_FILTER_CYC
) (
  input wire logic i_clk, // system clock
  input wire logic i_reset, // sync reset
  input wire logic i_level, // synchronised raw level
  output logic o_level, // filtered level
  output logic o_change // one-cycle pulse on accepted change
);
  typedef struct packed {
    logic level;
    logic change;
    logic [15:0] cnt;
  } wibs_flt_s;
  wibs_flt_s st;
  wibs_flt_s next_st;
  always_comb begin
    next_st = st;
    next_st.change = 1'b0;
    if (i_level == st.level) begin
      next_st.cnt = 16'h0000;
    end else if (st.cnt == 16'(CYCLES - 1)) begin
      next_st.level = i_level;
      next_st.change = 1'b1;
      next_st.cnt = 16'h0000;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_level = st.level;
  assign o_change = st.change;
  filter_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(st.change) |-> $past(st.cnt) == 16'(CYCLES - 1))
    else $error("filter accepted early");
endmodule

// >>> logic/wibs_pkg.sv
// types of the wake sense block
package wibs_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } wibs_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wibs_apb_rsp_s;
  typedef enum logic [1:0] {
    WIBS_RUN_NORMAL,
    WIBS_RUN_SLEEP,
    WIBS_RUN_RESTART
  } wibs_run_e;
endpackage

// >>> test/tb.sv
// register level bench of the wake sense block
`timescale 1ns/1ps
`include "wibs_consts.svh"
module tb;
  logic i_clk, i_reset, psel, penable, pwrite, hs_on, drv_en, drv_val;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, pu, pd, route, fo_en, fo_test, gpio_en;
  logic wk_int, wk_evt, wu_req, rs_req, irq, pin, wu_seen, rs_seen;
  logic [1:0] bias_lo [4];
  int error_cnt, n_checks, cyc;
  wibs_core DUT (.i_clk(i_clk), .i_reset(i_reset), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_hv_sense_pin(pin), .i_high_side_on(hs_on),
    .o_pull_up_en(pu), .o_pull_down_en(pd), .o_meas_route_en(route),
    .o_fail_out_en(fo_en), .o_fail_out_test_on(fo_test),
    .o_gpio_en(gpio_en), .o_wake_internal(wk_int), .o_wake_event(wk_evt),
    .o_wakeup_req(wu_req), .o_restart_req(rs_req), .o_irq(irq));
  wibs_line_model line (.i_clk(i_clk), .i_drive_en(drv_en),
    .i_drive_val(drv_val), .i_pull_up_en(pu), .i_pull_down_en(pd),
    .o_line(pin));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // pulse catchers and run limit
  always @(posedge i_clk) begin
    cyc++;
    if (wu_req === 1'b1) wu_seen = 1'b1;
    if (rs_req === 1'b1) rs_seen = 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task pin_set(input logic v);
    @(posedge i_clk);
    drv_en <= 1'b1;
    drv_val <= v;
  endtask
  // outputs as {route, fo_en, fo_test, gpio, wake, up, down}
  task outs(input logic [6:0] exp);
    @(negedge i_clk);
    chk({25'h0, route, fo_en, fo_test, gpio_en, wk_int, pu, pd}, exp);
  endtask
  initial begin
    {psel, penable, pwrite, hs_on, drv_val, wu_seen, rs_seen} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    drv_en = 1'b1;
    i_reset = 1'b1;
    bias_lo = '{2'h0, 2'h1, 2'h2, 2'h1};
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    rdchk(`WIBS_OFF_BIAS_CTRL, 32'h0);
    outs(7'h20);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr(`WIBS_OFF_BIAS_CTRL, c);
      wt(4);
      rdchk(`WIBS_OFF_FUNC_STAT, {30'h0, bias_lo[c]});
    end
    pin_set(1'b1);
    wt(5);
    rdchk(`WIBS_OFF_FUNC_STAT, 32'h2);
    $display("test bias done");
    // let the filter settle on the high level before wake is enabled
    wt(420);
    wr(`WIBS_OFF_WAKE_EN, 32'h1);
    wr(`WIBS_OFF_IRQ_EN, 32'h1);
    wr(`WIBS_OFF_IRQ_CLR, 32'h3);
    pin_set(1'b0);
    wt(200);
    pin_set(1'b1);
    wt(5);
    pin_set(1'b0);
    wt(370);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h0);
    wt(60);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h1);
    chk(irq, 1'b1);
    wr(`WIBS_OFF_IRQ_CLR, 32'h1);
    outs(7'h21);
    chk(irq, 1'b0);
    pin_set(1'b1);
    wt(420);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h1);
    rdchk(`WIBS_OFF_LVL_STAT, 32'h1);
    wr(`WIBS_OFF_IRQ_CLR, 32'h3);
    $display("test static filter done");
    wr(`WIBS_OFF_SLEEP_REQ, 32'h1);
    rdchk(`WIBS_OFF_FUNC_STAT, 32'h6);
    wu_seen = 1'b0;
    pin_set(1'b0);
    wt(420);
    chk(wu_seen, 1'b1);
    wr(`WIBS_OFF_IRQ_CLR, 32'h3);
    $display("test sleep wake done");
    // host has set the timer high-side switch; bench plays the timer
    wr(`WIBS_OFF_MODE, 32'h5);
    pin_set(1'b1);
    wt(20);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h0);
    hs_on <= 1'b1;
    wt(5);
    hs_on <= 1'b0;
    wt(5);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h1);
    pin_set(1'b0);
    wt(10);
    rdchk(`WIBS_OFF_LVL_STAT, 32'h1);
    $display("test cyclic done");
    wr(`WIBS_OFF_MODE, 32'h18);
    outs(7'h39);
    wr(`WIBS_OFF_MODE, 32'h1a);
    outs(7'h40);
    wr(`WIBS_OFF_BIAS_CTRL, 32'h2);
    rdchk(`WIBS_OFF_BIAS_CTRL, 32'h2);
    wr(`WIBS_OFF_WAKE_EN, 32'h0);
    rdchk(`WIBS_OFF_WAKE_EN, 32'h0);
    wr(`WIBS_OFF_WAKE_EN, 32'h1);
    wr(`WIBS_OFF_IRQ_CLR, 32'h3);
    pin_set(1'b1);
    wt(420);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h0);
    rdchk(`WIBS_OFF_LVL_STAT, 32'h0);
    outs(7'h40);
    apb(1'b0, 12'h024, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    rs_seen = 1'b0;
    wr(`WIBS_OFF_SLEEP_REQ, 32'h1);
    wt(5);
    chk(rs_seen, 1'b1);
    rdchk(`WIBS_OFF_EVT_STAT, 32'h2);
    rdchk(`WIBS_OFF_FUNC_STAT, 32'h0);
    $display("test measure done");
    final_report();
  end
endmodule

// >>> test/wibs_line_model.sv
// external wake line: a switch that drives it, or an open line
`timescale 1ns/1ps
module wibs_line_model (
  input wire logic i_clk, // system clock
  input wire logic i_drive_en, // switch closed, line driven
  input wire logic i_drive_val, // level of the closed switch
  input wire logic i_pull_up_en, // device pull-up source
  input wire logic i_pull_down_en, // device pull-down source
  output logic o_line // level seen by the device comparator
);
  initial o_line = 1'b0;
  // an open unbiased line is not trusted to hold, so it wanders
  always_ff @(posedge i_clk) begin
    if (i_drive_en) begin
      o_line <= i_drive_val;
    end else if (i_pull_up_en) begin
      o_line <= 1'b1;
    end else if (i_pull_down_en) begin
      o_line <= 1'b0;
    end else begin
      o_line <= ~o_line;
    end
  end
endmodule
